// file: idc_sector_buffer.sv
// Shared constants of the drive command engine, and its 256-word sector buffer.
// Assumes one clock, mclk, and a synchronous active-low reset in the user.
`timescale 1ns/100ps

package idc_pkg;
  // ****************************************
  // Task file addresses
  // ****************************************
  localparam logic [2:0] ADDR_DATA   = 3'h0;
  localparam logic [2:0] ADDR_ERR    = 3'h1;
  localparam logic [2:0] ADDR_SC     = 3'h2;
  localparam logic [2:0] ADDR_SN     = 3'h3;
  localparam logic [2:0] ADDR_CYLLO  = 3'h4;
  localparam logic [2:0] ADDR_CYLHI  = 3'h5;
  localparam logic [2:0] ADDR_SDH    = 3'h6;
  localparam logic [2:0] ADDR_CMD    = 3'h7;
  // ****************************************
  // Status and error bit positions
  // ****************************************
  localparam int STS_BSY  = 7;
  localparam int STS_DRDY = 6;
  localparam int STS_DSC  = 4;
  localparam int STS_DRQ  = 3;
  localparam int STS_ERR  = 0;
  localparam int ERR_UNC  = 6;
  localparam int ERR_IDNF = 4;
  localparam int ERR_ABRT = 2;
  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_VERIFY_RT = 8'h40;
  localparam logic [7:0] CMD_VERIFY_NR = 8'h41;
  localparam logic [7:0] CMD_FORMAT    = 8'h50;
  localparam logic [3:0] CMD_SEEK_HI   = 4'h7;
  localparam logic [7:0] CMD_INITP     = 8'h91;
  localparam logic [7:0] CMD_RDBUF     = 8'he4;
  localparam logic [7:0] CMD_WRBUF     = 8'he8;
  localparam logic [7:0] CMD_IDENT     = 8'hec;
  localparam logic [7:0] CMD_STBY0     = 8'he0;
  localparam logic [7:0] CMD_IDLE1     = 8'he1;
  localparam logic [7:0] CMD_STBY2     = 8'he2;
  localparam logic [7:0] CMD_IDLE3     = 8'he3;
  localparam logic [7:0] CMD_CHKPWR    = 8'he5;
  localparam logic [7:0] CMD_SLEEP     = 8'he6;
  // ****************************************
  // Format descriptors and power answers
  // ****************************************
  localparam logic [7:0] FMT_GOOD     = 8'h00;
  localparam logic [7:0] FMT_BAD      = 8'h80;
  localparam logic [7:0] FMT_ASSIGN   = 8'h40;
  localparam logic [7:0] FMT_UNASSIGN = 8'h20;
  localparam logic [7:0] SC_PWR_ON    = 8'hff;
  localparam logic [7:0] SC_PWR_DOWN  = 8'h00;
  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] RST_SC       = 8'h01;
  localparam logic [7:0] RST_SN       = 8'h01;
  localparam logic [8:0] VERIFY_MAX   = 9'h100;
  localparam logic [7:0] LAST_WORD    = 8'hff;
  // ****************************************
  // Identify block contents
  // ****************************************
  localparam logic [15:0] ID_SIGNATURE   = 16'h0a5a;
  localparam logic [15:0] ID_BYTES_TRACK = 16'h2800;
  localparam logic [15:0] ID_BYTES_SECT  = 16'h0240;
  localparam logic [15:0] ID_GAP_BYTES   = 16'h0010;
  localparam logic [15:0] ID_SYNC_BYTES  = 16'h000c;
  // Vendor, serial, firmware and model words are arbitrary values.
  localparam logic [15:0] ID_VENDOR      = 16'h0000;
  localparam logic [15:0] ID_SERIAL      = 16'h3030;
  localparam logic [15:0] ID_BUF_TYPE    = 16'h0001;
  localparam logic [15:0] ID_BUF_SIZE    = 16'h0001;
  localparam logic [15:0] ID_ECC_BYTES   = 16'h0007;
  localparam logic [15:0] ID_FIRMWARE    = 16'h3130;
  localparam logic [15:0] ID_MODEL       = 16'h2020;
  localparam logic [15:0] ID_SECT_IRQ    = 16'h0001;
  localparam logic [15:0] ID_DWORD       = 16'h0000;

  typedef enum logic [11:0] {
    ST_IDLE   = 12'h001,
    ST_EXEC   = 12'h002,
    ST_HOLD   = 12'h004,
    ST_VREQ   = 12'h008,
    ST_VWAIT  = 12'h010,
    ST_FMTIN  = 12'h020,
    ST_FLOOK  = 12'h040,
    ST_FPICK  = 12'h080,
    ST_FREQ   = 12'h100,
    ST_FWAIT  = 12'h200,
    ST_IDFILL = 12'h400,
    ST_XFER   = 12'h800
  } idc_state_e;

  typedef enum logic [2:0] {
    PWR_IDLE    = 3'h1,
    PWR_STANDBY = 3'h2,
    PWR_SLEEP   = 3'h4
  } idc_power_e;
endpackage : idc_pkg

// ****************************************
// Sector buffer
// ****************************************
// The read port is registered, so data for a new address appears one clock later.
module idc_sector_buffer #(
  parameter int DW = 16,
  parameter int AW = 8
) (
  input  wire logic          mclk,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge mclk) begin
    rdData <= mem[rdAddr];
  end
endmodule : idc_sector_buffer

// file: idc_command_engine.sv
// Command engine of the drive: task file, status, power state, sector buffer traffic.
// Assumes host strobes and media handshakes are synchronous to mclk.
`timescale 1ns/100ps

module idc_command_engine #(
  parameter logic [15:0] NUM_CYL      = 16'h0400,
  parameter logic [7:0]  NUM_HEADS    = 8'h08,
  parameter logic [7:0]  SECT_PER_TRK = 8'h11
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [2:0]  hostAddr,
  input  wire logic        hostWr,
  input  wire logic        hostRd,
  input  wire logic        hostAltRd,
  input  wire logic [15:0] hostWdata,
  output logic      [15:0] hostRdata,
  output logic             intrq,
  output logic             seekStart,
  output logic      [15:0] mediaCyl,
  output logic      [3:0]  mediaHead,
  output logic      [7:0]  mediaSector,
  input  wire logic        mediaSeekDone,
  output logic             verifyReq,
  input  wire logic        verifyDone,
  input  wire logic        verifyEccErr,
  output logic             fmtReq,
  output logic      [7:0]  fmtSector,
  output logic      [7:0]  fmtAction,
  input  wire logic        fmtDone,
  output logic      [2:0]  powerState
);
  idc_pkg::idc_state_e state;
  idc_pkg::idc_state_e stateNext;
  idc_pkg::idc_power_e power;
  logic [7:0]  curCmd, pendCmd, scReg, snReg, sdhReg, errReg, sptReg, headMaxReg;
  logic [15:0] cylReg;
  logic [8:0]  remain;
  logic [7:0]  ptr, ptrNext;
  logic        xferWrite, statusErr, seekBusy, bsy, drq;
  logic        cmdWr, stsRd, dataRd, dataWr, go, fin, setIdnf, setAbrt, setUnc;
  logic        verAdvance, initStore, bufWrEn, isVerify, isSeek, badLoc;
  logic [7:0]  goCmd, statusByte;
  logic [15:0] bufRd, bufWd;

  function automatic logic [15:0] identWord(input logic [7:0] idx);
    logic [15:0] w;
    w = 16'h0000;
    if (idx == 8'h00) w = idc_pkg::ID_SIGNATURE;
    else if (idx == 8'h01) w = NUM_CYL;
    else if (idx == 8'h03) w = {8'h00, NUM_HEADS};
    else if (idx == 8'h04) w = idc_pkg::ID_BYTES_TRACK;
    else if (idx == 8'h05) w = idc_pkg::ID_BYTES_SECT;
    else if (idx == 8'h06) w = {8'h00, SECT_PER_TRK};
    else if (idx == 8'h07) w = idc_pkg::ID_GAP_BYTES;
    else if (idx == 8'h08) w = idc_pkg::ID_SYNC_BYTES;
    else if (idx == 8'h09) w = idc_pkg::ID_VENDOR;
    else if (idx >= 8'h0a && idx <= 8'h13) w = idc_pkg::ID_SERIAL;
    else if (idx == 8'h14) w = idc_pkg::ID_BUF_TYPE;
    else if (idx == 8'h15) w = idc_pkg::ID_BUF_SIZE;
    else if (idx == 8'h16) w = idc_pkg::ID_ECC_BYTES;
    else if (idx >= 8'h17 && idx <= 8'h1a) w = idc_pkg::ID_FIRMWARE;
    else if (idx >= 8'h1b && idx <= 8'h2e) w = idc_pkg::ID_MODEL;
    else if (idx == 8'h2f) w = idc_pkg::ID_SECT_IRQ;
    else if (idx == 8'h30) w = idc_pkg::ID_DWORD;
    return w;
  endfunction : identWord

  // ****************************************
  // Host strobes and status
  // ****************************************
  assign bsy = !(state inside {idc_pkg::ST_IDLE, idc_pkg::ST_XFER, idc_pkg::ST_FMTIN});
  assign drq = state inside {idc_pkg::ST_XFER, idc_pkg::ST_FMTIN};
  assign cmdWr  = hostWr && hostAddr == idc_pkg::ADDR_CMD && !bsy;
  assign stsRd  = hostRd && hostAddr == idc_pkg::ADDR_CMD;
  assign dataRd = hostRd && hostAddr == idc_pkg::ADDR_DATA && state == idc_pkg::ST_XFER
                  && !xferWrite;
  assign dataWr = hostWr && hostAddr == idc_pkg::ADDR_DATA && (state == idc_pkg::ST_FMTIN
                  || (state == idc_pkg::ST_XFER && xferWrite));
  assign go    = (cmdWr && !seekBusy) || (state == idc_pkg::ST_HOLD && !seekBusy);
  assign goCmd = (state == idc_pkg::ST_HOLD) ? pendCmd : hostWdata[7:0];
  assign isVerify = curCmd == idc_pkg::CMD_VERIFY_RT || curCmd == idc_pkg::CMD_VERIFY_NR;
  assign isSeek   = curCmd[7:4] == idc_pkg::CMD_SEEK_HI;
  assign badLoc = cylReg >= NUM_CYL || {4'h0, sdhReg[3:0]} >= NUM_HEADS;

  always_comb begin
    statusByte = 8'h00;
    statusByte[idc_pkg::STS_BSY]  = bsy;
    statusByte[idc_pkg::STS_DRDY] = power != idc_pkg::PWR_SLEEP;
    statusByte[idc_pkg::STS_DSC]  = !seekBusy;
    statusByte[idc_pkg::STS_DRQ]  = drq;
    statusByte[idc_pkg::STS_ERR]  = statusErr;
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    stateNext = state;
    fin = 1'b0;
    setIdnf = 1'b0;
    setAbrt = 1'b0;
    setUnc = 1'b0;
    seekStart = 1'b0;
    verAdvance = 1'b0;
    initStore = 1'b0;
    unique case (state)
      idc_pkg::ST_IDLE, idc_pkg::ST_XFER, idc_pkg::ST_FMTIN: begin
        if (cmdWr) stateNext = seekBusy ? idc_pkg::ST_HOLD : idc_pkg::ST_EXEC;
        else if ((dataRd || dataWr) && ptr == idc_pkg::LAST_WORD)
          stateNext = (state == idc_pkg::ST_FMTIN) ? idc_pkg::ST_FLOOK : idc_pkg::ST_IDLE;
      end
      idc_pkg::ST_HOLD: begin
        if (go) stateNext = idc_pkg::ST_EXEC;
      end
      idc_pkg::ST_EXEC: begin
        stateNext = idc_pkg::ST_IDLE;
        fin = 1'b1;
        if (isVerify) begin
          stateNext = idc_pkg::ST_VREQ;
          fin = 1'b0;
        end else if (curCmd == idc_pkg::CMD_FORMAT) begin
          stateNext = idc_pkg::ST_FMTIN;
          fin = 1'b0;
        end else if (isSeek) begin
          setIdnf = cylReg >= NUM_CYL;
          seekStart = cylReg < NUM_CYL;
        end else if (curCmd == idc_pkg::CMD_INITP) begin
          initStore = 1'b1;
        end else if (curCmd == idc_pkg::CMD_RDBUF || curCmd == idc_pkg::CMD_WRBUF) begin
          stateNext = idc_pkg::ST_XFER;
        end else if (curCmd == idc_pkg::CMD_IDENT) begin
          stateNext = idc_pkg::ST_IDFILL;
          fin = 1'b0;
        end else if (!(curCmd inside {idc_pkg::CMD_STBY0, idc_pkg::CMD_IDLE1,
                       idc_pkg::CMD_STBY2, idc_pkg::CMD_IDLE3, idc_pkg::CMD_CHKPWR,
                       idc_pkg::CMD_SLEEP})) begin
          setAbrt = 1'b1;
        end
      end
      idc_pkg::ST_VREQ: begin
        stateNext = idc_pkg::ST_VWAIT;
        if (badLoc) begin
          setIdnf = 1'b1;
          fin = 1'b1;
          stateNext = idc_pkg::ST_IDLE;
        end
      end
      idc_pkg::ST_VWAIT: begin
        if (verifyDone) begin
          verAdvance = !verifyEccErr;
          setUnc = verifyEccErr;
          fin = verifyEccErr || remain == 9'h001;
          stateNext = fin ? idc_pkg::ST_IDLE : idc_pkg::ST_VREQ;
        end
      end
      idc_pkg::ST_FLOOK: stateNext = idc_pkg::ST_FPICK;
      idc_pkg::ST_FPICK: begin
        if (bufRd[15:8] != 8'h00) stateNext = idc_pkg::ST_FREQ;
        else if (ptr == idc_pkg::LAST_WORD) begin
          fin = 1'b1;
          stateNext = idc_pkg::ST_IDLE;
        end else stateNext = idc_pkg::ST_FLOOK;
      end
      idc_pkg::ST_FREQ: stateNext = idc_pkg::ST_FWAIT;
      idc_pkg::ST_FWAIT: begin
        if (fmtDone) begin
          fin = ptr == idc_pkg::LAST_WORD;
          stateNext = fin ? idc_pkg::ST_IDLE : idc_pkg::ST_FLOOK;
        end
      end
      idc_pkg::ST_IDFILL: begin
        if (ptr == idc_pkg::LAST_WORD) begin
          fin = 1'b1;
          stateNext = idc_pkg::ST_XFER;
        end
      end
      default: stateNext = idc_pkg::ST_IDLE;
    endcase
  end

  assign verifyReq = state == idc_pkg::ST_VREQ && !badLoc;
  assign fmtReq    = state == idc_pkg::ST_FREQ;

  always_ff @(posedge mclk) begin
    if (!resetn) state <= idc_pkg::ST_IDLE;
    else state <= stateNext;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      curCmd <= 8'h00;
      pendCmd <= 8'h00;
      xferWrite <= 1'b0;
    end else begin
      if (cmdWr) pendCmd <= hostWdata[7:0];
      if (go) curCmd <= goCmd;
      if (state == idc_pkg::ST_EXEC) xferWrite <= curCmd == idc_pkg::CMD_WRBUF;
      else if (state == idc_pkg::ST_IDFILL) xferWrite <= 1'b0;
    end
  end

  // ****************************************
  // Sector buffer traffic
  // ****************************************
  // The read port follows the next pointer, so its output always matches ptr.
  // Otherwise the first word after a pointer jump would be a stale one.
  always_comb begin
    ptrNext = ptr;
    if (state == idc_pkg::ST_EXEC) ptrNext = 8'h00;
    else if (dataRd || dataWr || state == idc_pkg::ST_IDFILL) ptrNext = ptr + 8'h01;
    else if (state == idc_pkg::ST_FMTIN && stateNext == idc_pkg::ST_FLOOK) ptrNext = 8'h00;
    else if (stateNext == idc_pkg::ST_FLOOK) ptrNext = ptr + 8'h01;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) ptr <= 8'h00;
    else ptr <= ptrNext;
  end

  assign bufWrEn = dataWr || state == idc_pkg::ST_IDFILL;
  assign bufWd   = (state == idc_pkg::ST_IDFILL) ? identWord(ptr) : hostWdata;

  idc_sector_buffer #(.DW(16), .AW(8)) u_buf (
    .mclk   (mclk),
    .wrEn   (bufWrEn),
    .wrAddr (ptr),
    .wrData (bufWd),
    .rdAddr (ptrNext),
    .rdData (bufRd)
  );

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fmtSector <= 8'h00;
      fmtAction <= idc_pkg::FMT_GOOD;
    end else if (state == idc_pkg::ST_FPICK) begin
      fmtSector <= bufRd[15:8];
      fmtAction <= bufRd[7:0];
    end
  end

  // ****************************************
  // Task file
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scReg <= idc_pkg::RST_SC;
      snReg <= idc_pkg::RST_SN;
      cylReg <= 16'h0000;
      sdhReg <= 8'h00;
    end else if (hostWr && !bsy) begin
      if (hostAddr == idc_pkg::ADDR_SC) scReg <= hostWdata[7:0];
      if (hostAddr == idc_pkg::ADDR_SN) snReg <= hostWdata[7:0];
      if (hostAddr == idc_pkg::ADDR_CYLLO) cylReg[7:0] <= hostWdata[7:0];
      if (hostAddr == idc_pkg::ADDR_CYLHI) cylReg[15:8] <= hostWdata[7:0];
      if (hostAddr == idc_pkg::ADDR_SDH) sdhReg <= hostWdata[7:0];
    end else if (state == idc_pkg::ST_EXEC && curCmd == idc_pkg::CMD_CHKPWR) begin
      scReg <= (power == idc_pkg::PWR_IDLE) ? idc_pkg::SC_PWR_ON : idc_pkg::SC_PWR_DOWN;
    end else if (verAdvance) begin
      scReg <= scReg - 8'h01;
      if (remain != 9'h001) begin
        if (snReg >= sptReg) begin
          snReg <= 8'h01;
          if (sdhReg[3:0] >= headMaxReg[3:0]) begin
            sdhReg[3:0] <= 4'h0;
            cylReg <= cylReg + 16'h0001;
          end else sdhReg[3:0] <= sdhReg[3:0] + 4'h1;
        end else snReg <= snReg + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) remain <= 9'h000;
    else if (state == idc_pkg::ST_EXEC && isVerify)
      remain <= (scReg == 8'h00) ? idc_pkg::VERIFY_MAX : {1'b0, scReg};
    else if (verAdvance) remain <= remain - 9'h001;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sptReg <= SECT_PER_TRK;
      headMaxReg <= NUM_HEADS - 8'h01;
    end else if (initStore) begin
      sptReg <= scReg;
      headMaxReg <= {4'h0, sdhReg[3:0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      errReg <= 8'h00;
      statusErr <= 1'b0;
    end else if (go) begin
      errReg <= 8'h00;
      statusErr <= 1'b0;
    end else if (setIdnf || setAbrt || setUnc) begin
      errReg[idc_pkg::ERR_IDNF] <= setIdnf;
      errReg[idc_pkg::ERR_ABRT] <= setAbrt;
      errReg[idc_pkg::ERR_UNC] <= setUnc;
      statusErr <= 1'b1;
    end
  end

  // ****************************************
  // Seek, power, interrupt and read data
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!resetn) seekBusy <= 1'b0;
    else if (seekStart) seekBusy <= 1'b1;
    else if (mediaSeekDone) seekBusy <= 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) power <= idc_pkg::PWR_IDLE;
    else if (state == idc_pkg::ST_EXEC) begin
      if (curCmd == idc_pkg::CMD_STBY0 || curCmd == idc_pkg::CMD_STBY2)
        power <= idc_pkg::PWR_STANDBY;
      else if (curCmd == idc_pkg::CMD_IDLE1 || curCmd == idc_pkg::CMD_IDLE3)
        power <= idc_pkg::PWR_IDLE;
      else if (curCmd == idc_pkg::CMD_SLEEP) power <= idc_pkg::PWR_SLEEP;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) intrq <= 1'b0;
    else intrq <= fin || (intrq && !stsRd && !cmdWr);
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hostRdata <= 16'h0000;
      mediaCyl <= 16'h0000;
      mediaHead <= 4'h0;
      mediaSector <= 8'h00;
    end else begin
      mediaCyl <= cylReg;
      mediaHead <= sdhReg[3:0];
      mediaSector <= snReg;
      if (hostAltRd) hostRdata <= {8'h00, statusByte};
      else if (hostRd) begin
        unique case (hostAddr)
          idc_pkg::ADDR_DATA:  hostRdata <= dataRd ? bufRd : 16'h0000;
          idc_pkg::ADDR_ERR:   hostRdata <= {8'h00, errReg};
          idc_pkg::ADDR_SC:    hostRdata <= {8'h00, scReg};
          idc_pkg::ADDR_SN:    hostRdata <= {8'h00, snReg};
          idc_pkg::ADDR_CYLLO: hostRdata <= {8'h00, cylReg[7:0]};
          idc_pkg::ADDR_CYLHI: hostRdata <= {8'h00, cylReg[15:8]};
          idc_pkg::ADDR_SDH:   hostRdata <= {8'h00, sdhReg};
          idc_pkg::ADDR_CMD:   hostRdata <= {8'h00, statusByte};
        endcase
      end
    end
  end

  assign powerState = power;

  // ****************************************
  // Checks
  // ****************************************
  // quiet verify
  chk_verify_quiet: assert property (@(posedge mclk) disable iff (!resetn)
    state inside {idc_pkg::ST_VREQ, idc_pkg::ST_VWAIT} |-> !intrq && !drq)
    else $error("Interrupt or DRQ during verify.");
  chk_verify_zero: assert property (@(posedge mclk) disable iff (!resetn)
    state == idc_pkg::ST_EXEC && isVerify && scReg == 8'h00 |=> remain == 9'h100)
    else $error("Zero sector count not taken as 256.");
  chk_seek_quick: assert property (@(posedge mclk) disable iff (!resetn)
    go && goCmd[7:4] == idc_pkg::CMD_SEEK_HI |=> bsy ##1 (!bsy && intrq))
    else $error("Seek did not release BSY with interrupt.");
  chk_dsc_motion: assert property (@(posedge mclk) disable iff (!resetn)
    seekStart |=> !statusByte[idc_pkg::STS_DSC])
    else $error("Seek complete shown during motion.");
  chk_dsc_rise: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(statusByte[idc_pkg::STS_DSC]) |-> $past(mediaSeekDone))
    else $error("Seek complete shown before motion ended.");
  chk_hold_busy: assert property (@(posedge mclk) disable iff (!resetn)
    cmdWr && seekBusy |=> state == idc_pkg::ST_HOLD && bsy)
    else $error("Command started during seek.");
  chk_seek_idnf: assert property (@(posedge mclk) disable iff (!resetn)
    state == idc_pkg::ST_EXEC && isSeek && cylReg >= NUM_CYL
      |=> errReg[idc_pkg::ERR_IDNF] && statusErr && !seekBusy)
    else $error("Illegal cylinder not flagged.");
  chk_buf_ready: assert property (@(posedge mclk) disable iff (!resetn)
    go && goCmd == idc_pkg::CMD_RDBUF |=> ##1 (drq && intrq && !bsy))
    else $error("Read buffer not opened.");
  chk_power_check: assert property (@(posedge mclk) disable iff (!resetn)
    state == idc_pkg::ST_EXEC && curCmd == idc_pkg::CMD_CHKPWR && power == idc_pkg::PWR_IDLE
      |=> scReg == idc_pkg::SC_PWR_ON)
    else $error("Power check answer wrong.");
  chk_irq_clear: assert property (@(posedge mclk) disable iff (!resetn)
    stsRd && !fin |=> !intrq)
    else $error("Status read left interrupt set.");
  chk_irq_hold: assert property (@(posedge mclk) disable iff (!resetn)
    intrq && !stsRd && !cmdWr |=> intrq)
    else $error("Interrupt dropped early.");
endmodule : idc_command_engine

// file: idc_media_model.sv
// Media model: answers seek, verify and format requests after a fixed delay.
// Assumes one-cycle request pulses on mclk and answers with one-cycle pulses.
`timescale 1ns/100ps
module idc_media_model #(
  parameter int DLY = 20
) (
  input  wire logic mclk,
  input  wire logic seekStart,
  input  wire logic verifyReq,
  input  wire logic fmtReq,
  output logic      mediaSeekDone,
  output logic      verifyDone,
  output logic      verifyEccErr,
  output logic      fmtDone
);
  logic [DLY-1:0] skPipe = '0;
  logic [DLY-1:0] vfPipe = '0;
  logic [DLY-1:0] fmPipe = '0;
  // ****************************************
  // Mechanics
  // ****************************************
  // seek ends late.
  // The long delay leaves room to see status while heads still move.
  always_ff @(posedge mclk) begin
    skPipe <= {skPipe[DLY-2:0], seekStart};
    vfPipe <= {vfPipe[DLY-2:0], verifyReq};
    fmPipe <= {fmPipe[DLY-2:0], fmtReq};
  end
  assign mediaSeekDone = skPipe[DLY-1];
  assign verifyDone    = vfPipe[DLY-1];
  assign verifyEccErr  = 1'b0;
  assign fmtDone       = fmPipe[DLY-1];
endmodule : idc_media_model

// file: ide_drive_command_engine_test.sv
// Testbench of the drive command engine with a media model.
// Assumes the engine and its package are compiled first.
`timescale 1ns/100ps
module ide_drive_command_engine_test;
  logic        mclk = 0, resetn = 0, hostWr = 0, hostRd = 0, hostAltRd = 0;
  logic [2:0]  hostAddr = '0;
  logic [15:0] hostWdata = '0, hostRdata;
  logic        intrq, seekStart, verifyReq, fmtReq, skDone, vDone, vErr, fDone;
  logic [2:0]  powerState;
  logic [15:0] mediaCyl;
  logic [7:0]  mediaSector, fmtSector, fmtAction;
  logic [3:0]  mediaHead;
  logic [15:0] fQ[$];
  localparam logic [7:0] FD[4] = '{idc_pkg::FMT_GOOD, idc_pkg::FMT_BAD, idc_pkg::FMT_ASSIGN,
                                   idc_pkg::FMT_UNASSIGN};
  logic [16:0] expQ[$];
  logic [15:0] wbuf[256];
  int          failures = 0, samples_checked = 0, vCount = 0;
  localparam logic [7:0] PW[5] = '{8'he0, 8'he6, 8'he1, 8'he2, 8'he3};
  localparam logic [2:0] PS[5] = '{3'h2, 3'h4, 3'h1, 3'h2, 3'h1};
  always #20 mclk = ~mclk;
  idc_command_engine idc_command_engine_inst (.mclk(mclk), .resetn(resetn),
    .hostAddr(hostAddr), .hostWr(hostWr), .hostRd(hostRd), .hostAltRd(hostAltRd),
    .hostWdata(hostWdata), .hostRdata(hostRdata), .intrq(intrq), .seekStart(seekStart),
    .mediaCyl(mediaCyl), .mediaHead(mediaHead), .mediaSector(mediaSector),
    .mediaSeekDone(skDone),
    .verifyReq(verifyReq), .verifyDone(vDone), .verifyEccErr(vErr), .fmtReq(fmtReq),
    .fmtSector(fmtSector), .fmtAction(fmtAction), .fmtDone(fDone), .powerState(powerState));
  idc_media_model idc_media_model_inst (.mclk(mclk), .seekStart(seekStart),
    .verifyReq(verifyReq), .fmtReq(fmtReq), .mediaSeekDone(skDone),
    .verifyDone(vDone), .verifyEccErr(vErr), .fmtDone(fDone));
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (exp !== got) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic stop_test;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic wr(logic [2:0] a, logic [15:0] d);
    hostAddr = a; hostWdata = d; hostWr = 1;
    @(negedge mclk) hostWr = 0;
    @(negedge mclk);
  endtask : wr
  task automatic rd(logic [2:0] a, logic [16:0] e, logic alt = 0);
    expQ.push_back(e); hostAddr = a; hostRd = !alt; hostAltRd = alt;
    @(negedge mclk) {hostRd, hostAltRd} = 2'b00;
    @(negedge mclk);
  endtask : rd
  task automatic waitIrq(int n);
    repeat (n) if (intrq !== 1'b1) @(negedge mclk);
    check("intrq", 16'h1, {15'h0, intrq});
  endtask : waitIrq
  // Bit 16 of a note asks for all sixteen bits; otherwise only the byte counts.
  always @(posedge mclk) if (hostRd || hostAltRd) begin
    @(negedge mclk);
    check(expQ[0][16] ? "data" : "taskfile", expQ[0][15:0],
          expQ[0][16] ? hostRdata : {8'h00, hostRdata[7:0]});
    void'(expQ.pop_front());
  end
  always @(posedge mclk) if (verifyReq === 1'b1) vCount++;
  always @(negedge mclk) if (fmtReq === 1'b1) begin
    check("format word", fQ[0], {fmtSector, fmtAction});
    void'(fQ.pop_front());
  end
  always @(negedge mclk) if (seekStart === 1'b1)
    check("seek cylinder", 16'h0003, mediaCyl);
  always @(negedge mclk) if (verifyReq === 1'b1 && vCount == 0)
    check("verify start", 16'h0001, {4'h0, mediaHead, mediaSector});
  initial begin
    #1000000 failures++;
    stop_test();
  end
  initial begin
    void'($urandom(40453));
    repeat (16) @(negedge mclk);
    resetn = 1;
    rd(idc_pkg::ADDR_CMD, 17'h00050);
    wr(idc_pkg::ADDR_CYLLO, 16'h0003);
    wr(idc_pkg::ADDR_CMD, 16'h0070);
    waitIrq(4);
    rd(idc_pkg::ADDR_CMD, 17'h00040, 1);
    check("intrq", 16'h1, {15'h0, intrq});
    rd(idc_pkg::ADDR_CMD, 17'h00040);
    check("intrq", 16'h0, {15'h0, intrq});
    repeat (30) @(negedge mclk);
    rd(idc_pkg::ADDR_CMD, 17'h00050);
    wr(idc_pkg::ADDR_CMD, 16'h0070);
    wr(idc_pkg::ADDR_CMD, 16'h00e5);
    rd(idc_pkg::ADDR_CMD, 17'h000c0);
    waitIrq(40);
    rd(idc_pkg::ADDR_SC, 17'h000ff);
    wr(idc_pkg::ADDR_CYLHI, 16'h0004);
    wr(idc_pkg::ADDR_CMD, 16'h0070);
    waitIrq(4);
    rd(idc_pkg::ADDR_ERR, 17'h00010);
    rd(idc_pkg::ADDR_CMD, 17'h00051);
    wr(idc_pkg::ADDR_CYLHI, 16'h0000);
    wr(idc_pkg::ADDR_CMD, 16'h00e8);
    waitIrq(4);
    for (int i = 0; i < 256; i++) begin
      wbuf[i] = 16'($urandom);
      wr(idc_pkg::ADDR_DATA, wbuf[i]);
    end
    wr(idc_pkg::ADDR_CMD, 16'h00e4);
    waitIrq(4);
    for (int i = 0; i < 256; i++) rd(idc_pkg::ADDR_DATA, {1'b1, wbuf[i]});
    wr(idc_pkg::ADDR_CMD, 16'h0050);
    rd(idc_pkg::ADDR_CMD, 17'h00058);
    for (int i = 0; i < 256; i++) begin
      wbuf[i] = (i < 4) ? {8'(i + 1), FD[i % 4]} : 16'h0000;
      if (i < 4) fQ.push_back(wbuf[i]);
      wr(idc_pkg::ADDR_DATA, wbuf[i]);
    end
    waitIrq(900);
    check("format count", 16'h0000, 16'(fQ.size()));
    wr(idc_pkg::ADDR_CMD, 16'h00ec);
    waitIrq(300);
    rd(idc_pkg::ADDR_DATA, {1'b1, idc_pkg::ID_SIGNATURE});
    rd(idc_pkg::ADDR_DATA, 17'h10400);
    rd(idc_pkg::ADDR_DATA, 17'h10000);
    rd(idc_pkg::ADDR_DATA, 17'h10008);
    wr(idc_pkg::ADDR_SDH, 16'h0003);
    wr(idc_pkg::ADDR_SC, 16'h0004);
    wr(idc_pkg::ADDR_CMD, 16'h0091);
    waitIrq(4);
    wr(idc_pkg::ADDR_SDH, 16'h0000);
    wr(idc_pkg::ADDR_SC, 16'h0000);
    wr(idc_pkg::ADDR_CMD, 16'h0040);
    waitIrq(8000);
    check("verify count", 16'd256, 16'(vCount));
    rd(idc_pkg::ADDR_SC, 17'h00000);
    rd(idc_pkg::ADDR_CYLLO, 17'h00012);
    rd(idc_pkg::ADDR_SN, 17'h00004);
    rd(idc_pkg::ADDR_SDH, 17'h00003);
    foreach (PW[i]) begin
      wr(idc_pkg::ADDR_CMD, {8'h00, PW[i]});
      repeat (4) @(negedge mclk);
      check("power", {13'h0, PS[i]}, {13'h0, powerState});
      wr(idc_pkg::ADDR_CMD, 16'h00e5);
      repeat (4) @(negedge mclk);
      rd(idc_pkg::ADDR_SC, {9'h0, (PS[i] == 3'h1) ? 8'hff : 8'h00});
    end
    stop_test();
  end
endmodule : ide_drive_command_engine_test
